// *** hw/umf_cfg_if.sv ***
// Configuration and timing shared by the receive and transmit paths.
// Driven by the top module, read by both serial engines.
interface umf_cfg_if;
  logic [2:0] char_size;
  logic       two_stop;
  logic       tick;
  modport src (output char_size, output two_stop, output tick);
  modport rx  (input char_size, input tick);
  modport tx  (input char_size, input two_stop, input tick);
endinterface

// *** hw/umf_pkg.sv ***
// Shared constants for the multidrop address filter serial block.
// Assumes a single 100 MHz clock and a 32-bit APB register port.
package umf_pkg;
  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;
  localparam logic [7:0]  ADDR_MASK      = 8'h08;
  localparam logic [7:0]  ADDR_RXDATA    = 8'h0c;
  localparam logic [7:0]  ADDR_TXDATA    = 8'h10;
  localparam logic [7:0]  ADDR_BAUD      = 8'h14;
  localparam int          CTRL_FILTER    = 0;
  localparam int          CTRL_SIZE_LSB  = 1;
  localparam int          CTRL_STOP2     = 4;
  localparam int          CTRL_TX9       = 5;
  localparam logic [5:0]  CTRL_RESET     = 6'h06;
  localparam int          ST_RXC         = 0;
  localparam int          ST_TXC         = 1;
  localparam int          ST_FE          = 2;
  localparam int          ST_DROP        = 3;
  localparam int          ST_W           = 4;
  localparam int          ST_TX_BUSY     = 8;
  localparam logic [3:0]  MASK_RESET     = 4'h0;
  localparam logic [15:0] BAUD_RESET     = 16'h0000;
  localparam logic [2:0]  SIZE_NINE      = 3'h7;
  // ----------------------------------------------------------------
  // Bit timing, in ticks of the oversampling clock
  // ----------------------------------------------------------------
  localparam logic [3:0]  SAMPLE_LAST    = 4'hf;
  localparam logic [3:0]  VOTE_A         = 4'h7;
  localparam logic [3:0]  VOTE_B         = 4'h8;
  localparam logic [3:0]  VOTE_C         = 4'h9;

  // Size codes 0..3 give five to eight bits; reserved codes act as eight.
  function automatic logic [3:0] data_bits(input logic [2:0] size);
    logic [3:0] n;
    n = 4'h8;
    if (size == SIZE_NINE) begin
      n = 4'h9;
    end else if (size < 3'h4) begin
      n = 4'h5 + {2'h0, size[1:0]};
    end
    return n;
  endfunction

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction
endpackage

// *** hw/umf_rx.sv ***
// Serial receive engine with three-sample majority voting.
// Assumes rxd_in is synchronous to clk_in and tick runs at sixteen per bit.
module umf_rx (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // Configuration
  umf_cfg_if.rx           cfg,
  // Line and frame result
  input  wire logic       rxd_in,
  output logic            done_out,
  output logic [8:0]      data_out,
  output logic            stop_out
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} umf_rx_e;

  umf_rx_e    state_q;
  logic [3:0] sample_q;
  logic [3:0] bit_q;
  logic [1:0] votes_q;
  logic       voted;
  logic [3:0] nbits;

  assign voted = umf_pkg::maj3(votes_q[0], votes_q[1], rxd_in);
  assign nbits = umf_pkg::data_bits(cfg.char_size);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q  <= RX_IDLE;
      sample_q <= 4'h0;
      bit_q    <= 4'h0;
      votes_q  <= 2'h0;
      data_out <= 9'h000;
      stop_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (cfg.tick) begin
        sample_q <= sample_q + 4'h1;
        if (sample_q == umf_pkg::VOTE_A) votes_q[0] <= rxd_in;
        if (sample_q == umf_pkg::VOTE_B) votes_q[1] <= rxd_in;
        unique case (state_q)
          RX_IDLE: begin
            sample_q <= 4'h0;
            if (!rxd_in) begin
              state_q <= RX_START;
            end
          end
          RX_START: begin
            // A start bit gone high by mid-bit is taken as a glitch.
            if (sample_q == umf_pkg::VOTE_B && rxd_in) begin
              state_q <= RX_IDLE;
            end else if (sample_q == umf_pkg::SAMPLE_LAST) begin
              state_q  <= RX_BITS;
              bit_q    <= 4'h0;
              data_out <= 9'h000;
            end
          end
          RX_BITS: begin
            if (sample_q == umf_pkg::VOTE_C) begin
              data_out[bit_q] <= voted;
            end
            if (sample_q == umf_pkg::SAMPLE_LAST) begin
              bit_q <= bit_q + 4'h1;
              if (bit_q == nbits - 4'h1) begin
                state_q <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            // Only the first stop bit is looked at; the frame ends at its vote.
            if (sample_q == umf_pkg::VOTE_C) begin
              stop_out <= voted;
              done_out <= 1'b1;
              state_q  <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule

// *** hw/umf_top.sv ***
// Serial transceiver with a multidrop address filter on the receive path.
// Assumes APB from a 100 MHz system clock and a line synchronous to it.
//
// Behaviour
// R01 - With the filter enabled, every frame not marked as an address is dropped unbuffered.
// R02 - The transmitter never looks at the filter enable.
// R03 - For five to eight data bits the first stop bit is the frame type.
// R04 - For nine data bits the received ninth bit is the frame type.
// R05 - A type of one means an address frame and zero means a data frame.
// R06 - An address frame under the filter is buffered and flags receive complete as usual.
// R07 - A nine-bit master uses size code 7 and sends the ninth bit high only for addresses.
// R08 - All slaves use the nine-bit format when the master does.
// R09 - A slave compares each address with its own and clears the filter when selected.
// R10 - With the filter clear all data frames are taken; with it set they are dropped.
// R11 - After its last data frame the selected slave sets the filter again.
// R12 - With five to eight bits the transmitter uses two stop bits in multidrop use.
// R13 - Transmit and receive share one character size setting.
// R14 - Software does not change the filter bit by read-modify-write near the transmit flag.
// R15 - A majority-voted first stop bit of zero raises the frame error flag. Here it is raised only for frames that are accepted, not for dropped ones.
//
// Chosen here: the register addresses and the APB interface to the registers.
module umf_top (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // APB slave
  input  wire logic [7:0]  paddr_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Serial line
  input  wire logic        rxd_in,
  output logic             txd_out,
  // Interrupt
  output logic             irq_out
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0]             ctrl_q;
  logic [umf_pkg::ST_W-1:0] status_q;
  logic [umf_pkg::ST_W-1:0] status_d;
  logic [umf_pkg::ST_W-1:0] mask_q;
  logic [8:0]             serial_data_buffer_q;
  logic [8:0]             tx_hold_q;
  logic                   tx_start_q;
  logic [15:0]            baud_divisor_q;
  logic [15:0]            baud_cnt_q;
  logic                   slverr_q;

  // ----------------------------------------------------------------
  // Named control fields
  // ----------------------------------------------------------------
  logic       multidrop_filter_enable;
  logic [2:0] character_size_select;
  logic       stop_bit_count_select;
  logic       transmit_ninth_bit;

  assign multidrop_filter_enable = ctrl_q[umf_pkg::CTRL_FILTER];
  assign character_size_select   = ctrl_q[umf_pkg::CTRL_SIZE_LSB +: 3];
  assign stop_bit_count_select   = ctrl_q[umf_pkg::CTRL_STOP2];
  assign transmit_ninth_bit      = ctrl_q[umf_pkg::CTRL_TX9];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        access;
  logic        respond;
  logic        commit;
  logic        wr;
  logic        hit_ctrl;
  logic        hit_status;
  logic        hit_mask;
  logic        hit_rx;
  logic        hit_tx;
  logic        hit_baud;
  logic        mapped;
  logic        tx_busy;
  logic        tx_refused;
  logic [31:0] read_word;

  assign access     = psel_in && penable_in;
  assign respond    = access && !pready_out;
  assign commit     = access && pready_out && !slverr_q;
  assign wr         = commit && pwrite_in;
  assign hit_ctrl   = paddr_in == umf_pkg::ADDR_CTRL;
  assign hit_status = paddr_in == umf_pkg::ADDR_STATUS;
  assign hit_mask   = paddr_in == umf_pkg::ADDR_MASK;
  assign hit_rx     = paddr_in == umf_pkg::ADDR_RXDATA;
  assign hit_tx     = paddr_in == umf_pkg::ADDR_TXDATA;
  assign hit_baud   = paddr_in == umf_pkg::ADDR_BAUD;
  assign mapped     = hit_ctrl | hit_status | hit_mask | hit_rx | hit_tx | hit_baud;
  // A second character cannot be queued: the write is answered with an error.
  assign tx_refused = pwrite_in && hit_tx && (tx_busy || tx_start_q);

  always_comb begin
    read_word = 32'h0000_0000;
    if (hit_ctrl) begin
      read_word[5:0] = ctrl_q;
    end else if (hit_status) begin
      read_word[umf_pkg::ST_W-1:0] = status_q;
      read_word[umf_pkg::ST_TX_BUSY] = tx_busy;
    end else if (hit_mask) begin
      read_word[umf_pkg::ST_W-1:0] = mask_q;
    end else if (hit_rx) begin
      read_word[8:0] = serial_data_buffer_q;
    end else if (hit_tx) begin
      read_word[8:0] = tx_hold_q;
    end else if (hit_baud) begin
      read_word[15:0] = baud_divisor_q;
    end
  end

  // Answer on the second access cycle, so pready and pslverr come from flops.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      slverr_q    <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out <= respond;
      if (respond) begin
        slverr_q    <= !mapped || tx_refused;
        pslverr_out <= !mapped || tx_refused;
        prdata_out  <= pwrite_in ? 32'h0000_0000 : read_word;
      end else begin
        slverr_q    <= 1'b0;
        pslverr_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // The filter bit lives apart from the event flags, and those clear only
  // on a written one, so a read-modify-write of control loses no event.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_q         <= umf_pkg::CTRL_RESET;
      mask_q         <= umf_pkg::MASK_RESET;
      baud_divisor_q <= umf_pkg::BAUD_RESET;
    end else begin
      if (wr && hit_ctrl) begin
        ctrl_q <= pwdata_in[5:0]; // R09 R11 R14
      end
      if (wr && hit_mask) begin
        mask_q <= pwdata_in[umf_pkg::ST_W-1:0];
      end
      if (wr && hit_baud) begin
        baud_divisor_q <= pwdata_in[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Oversampling tick and shared configuration
  // ----------------------------------------------------------------
  umf_cfg_if cfg ();

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      baud_cnt_q <= 16'h0000;
    end else if (cfg.tick) begin
      baud_cnt_q <= 16'h0000;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
    end
  end

  assign cfg.tick      = baud_cnt_q >= baud_divisor_q;
  assign cfg.char_size = character_size_select; // R13 R08
  assign cfg.two_stop  = stop_bit_count_select; // R12

  // ----------------------------------------------------------------
  // Receive path and address filter
  // ----------------------------------------------------------------
  logic       rx_done;
  logic [8:0] rx_data;
  logic       rx_stop;
  logic       frame_type;
  logic       is_address;
  logic       accept;
  logic       drop;

  umf_rx u_rx (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .cfg      (cfg),
    .rxd_in   (rxd_in),
    .done_out (rx_done),
    .data_out (rx_data),
    .stop_out (rx_stop)
  );

  assign frame_type = (character_size_select == umf_pkg::SIZE_NINE) ?
                      rx_data[8] : rx_stop; // R03 R04
  assign is_address = frame_type == 1'b1; // R05
  assign accept     = rx_done && (!multidrop_filter_enable || is_address); // R06 R10
  assign drop       = rx_done && multidrop_filter_enable && !is_address; // R01

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_data_buffer_q <= 9'h000;
    end else if (accept) begin
      serial_data_buffer_q <= rx_data; // R01 R06
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic tx_done;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_hold_q  <= 9'h000;
      tx_start_q <= 1'b0;
    end else begin
      tx_start_q <= wr && hit_tx;
      if (wr && hit_tx) begin
        tx_hold_q <= {transmit_ninth_bit, pwdata_in[7:0]}; // R07
      end
    end
  end

  // The transmitter sees size, stops and data only, never the filter.
  umf_tx u_tx (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .cfg      (cfg), // R02
    .start_in (tx_start_q),
    .data_in  (tx_hold_q),
    .txd_out  (txd_out),
    .busy_out (tx_busy),
    .done_out (tx_done)
  );

  // ----------------------------------------------------------------
  // Event flags and interrupt
  // ----------------------------------------------------------------
  logic [umf_pkg::ST_W-1:0] ev_set;
  logic [umf_pkg::ST_W-1:0] ev_clr;

  always_comb begin
    ev_set                  = '0;
    ev_set[umf_pkg::ST_RXC]  = accept;
    ev_set[umf_pkg::ST_TXC]  = tx_done;
    ev_set[umf_pkg::ST_FE]   = accept && !rx_stop; // R15
    ev_set[umf_pkg::ST_DROP] = drop;
  end

  assign ev_clr   = (wr && hit_status) ? pwdata_in[umf_pkg::ST_W-1:0] : '0;
  // A new event in the clearing cycle survives the clear.
  assign status_d = (status_q & ~ev_clr) | ev_set;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_q <= '0;
      irq_out  <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_out  <= |(status_d & mask_q);
    end
  end
endmodule

// *** hw/umf_tx.sv ***
// Serial transmit engine: start bit, five to nine data bits, one or two stops.
// Assumes tick runs at sixteen per bit; start_in is a one-cycle pulse.
module umf_tx (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // Configuration
  umf_cfg_if.tx           cfg,
  // Character request
  input  wire logic       start_in,
  input  wire logic [8:0] data_in,
  // Line and status
  output logic            txd_out,
  output logic            busy_out,
  output logic            done_out
);
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} umf_tx_e;

  umf_tx_e    state_q;
  logic [3:0] sample_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic       second_q;
  logic       bit_end;

  assign bit_end = cfg.tick && sample_q == umf_pkg::SAMPLE_LAST;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_q  <= TX_IDLE;
      sample_q <= 4'h0;
      bit_q    <= 4'h0;
      shift_q  <= 9'h000;
      second_q <= 1'b0;
      txd_out  <= 1'b1;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (cfg.tick) begin
        sample_q <= sample_q + 4'h1;
      end
      unique case (state_q)
        TX_IDLE: begin
          if (start_in) begin
            state_q  <= TX_START;
            shift_q  <= data_in;
            sample_q <= 4'h0;
            txd_out  <= 1'b0;
            busy_out <= 1'b1;
          end
        end
        TX_START: begin
          if (bit_end) begin
            state_q <= TX_BITS;
            bit_q   <= 4'h0;
            txd_out <= shift_q[0];
          end
        end
        TX_BITS: begin
          if (bit_end) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == umf_pkg::data_bits(cfg.char_size) - 4'h1) begin
              state_q  <= TX_STOP;
              second_q <= 1'b0;
              txd_out  <= 1'b1;
            end else begin
              txd_out <= shift_q[bit_q + 4'h1];
            end
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            if (cfg.two_stop && !second_q) begin
              second_q <= 1'b1;
            end else begin
              state_q  <= TX_IDLE;
              busy_out <= 1'b0;
              done_out <= 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule

// *** verif/umf_line_model.sv ***
// Far-end serial talker that drives the receive line of umf_top.
// Assumes BAUD stays 0, so one bit lasts sixteen system clocks.
module umf_line_model (
  // Clock
  input  wire logic clk_in,
  // Line
  output logic      rxd_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // The line rests at its pull-up level between frames.
  initial rxd_out = 1'b1;

  task automatic put_bit(input logic b);
    @(posedge clk_in);
    rxd_out <= b;
    repeat (15) @(posedge clk_in);
  endtask

  // Start bit, data LSB first, then the type-carrying stop bit and a true stop bit.
  task automatic send(input logic [8:0] data, input int nbits, input logic type_bit);
    put_bit(1'b0);
    for (int i = 0; i < nbits; i++) begin
      put_bit(data[i]);
    end
    put_bit(type_bit);
    put_bit(1'b1);
  endtask
endmodule

// *** verif/umf_properties.sv ***
// Port checks for umf_top: APB answer timing, error answers, irq and txd.
// Assumes a master that holds each request until pready is seen high.
module umf_props (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        reset_in,
  // APB
  input wire logic [7:0]  paddr_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Line and interrupt
  input wire logic        txd_out,
  input wire logic        irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ------------------------------------------------------------
  // Decodes
  // ------------------------------------------------------------
  wire done_w = psel_in && penable_in && pready_out;
  wire hole_w = paddr_in > 8'h14;
  wire txgo_w = done_w && pwrite_in && !pslverr_out && paddr_in == umf_pkg::ADDR_TXDATA;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_ready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready missing in second access cycle");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("pready without access");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_hole_error: assert property (done_w && hole_w |-> pslverr_out)
    else $error("unmapped access not refused");
  a_hole_reads_zero: assert property (done_w && hole_w && !pwrite_in |-> prdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_write_data_zero: assert property (done_w && pwrite_in |-> prdata_out == 32'h0)
    else $error("read data not zero on write");
  a_irq_clear: assert property ($fell(irq_out) |->
                                $past(done_w && pwrite_in) || $past(done_w && pwrite_in, 2))
    else $error("irq fell without a write");
  a_tx_start: assert property (txgo_w |-> ##[1:3] !txd_out)
    else $error("accepted character did not start");
  a_start_length: assert property ($fell(txd_out) |-> !txd_out [*8])
    else $error("start bit too short");
  cover property (done_w && pslverr_out);
  cover property ($rose(irq_out));
  cover property ($fell(txd_out));
endmodule

// *** verif/umf_top_tb.sv ***
// Self-checking bench for umf_top: register access, filtering, irq, transmit.
// Assumes the line model drives rxd_in and BAUD keeps its reset value of 0.
module umf_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  paddr_in = 8'h0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        rxd_in;
  logic        txd_out;
  logic        irq_out;
  logic [31:0] rdata;
  logic        rerr;
  int          error_cnt = 0;
  int          checks_done = 0;

  always #5 clk_in = ~clk_in;

  umf_top uut (.clk_in, .reset_in, .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .rxd_in, .txd_out, .irq_out);
  umf_line_model line (.clk_in, .rxd_out(rxd_in));
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The answer is taken at the rising edge where pready is sampled high, as the slave
  // sees that edge, and the request is released right after it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready_out});
    rdata = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask

  task automatic clr();
    wr(umf_pkg::ADDR_STATUS, 32'h0f);
  endtask

  // A mask write moves irq one edge after its commit, so look one edge later.
  task automatic irq_is(input logic exp);
    @(posedge clk_in);
    @(negedge clk_in);
    chk("irq", {31'h0, exp}, {31'h0, irq_out});
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd("ctrl", umf_pkg::ADDR_CTRL, {26'h0, umf_pkg::CTRL_RESET});
    rd("mask", umf_pkg::ADDR_MASK, 32'h0);
    rd("status", umf_pkg::ADDR_STATUS, 32'h0);
    rd("rxdata", umf_pkg::ADDR_RXDATA, 32'h0);
    rd("baud", umf_pkg::ADDR_BAUD, 32'h0);
    rd("unmapped", 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
  endtask

  task automatic t_sizes();
    for (int s = 0; s < 4; s++) begin
      clr();
      wr(umf_pkg::ADDR_CTRL, 32'(s * 2 + 1));
      line.send(9'h0aa, 5 + s, 1'b0);
      rd("data dropped", umf_pkg::ADDR_STATUS, 32'h8);
      line.send(9'h0d3, 5 + s, 1'b1);
      rd("addr taken", umf_pkg::ADDR_STATUS, 32'h9);
      rd("addr data", umf_pkg::ADDR_RXDATA, 32'h0d3 & ((32'h1 << (5 + s)) - 32'h1));
    end
  endtask

  task automatic t_nine();
    clr();
    wr(umf_pkg::ADDR_CTRL, 32'h0f);
    line.send(9'h155, 9, 1'b1);
    rd("addr9 status", umf_pkg::ADDR_STATUS, 32'h1);
    rd("addr9 data", umf_pkg::ADDR_RXDATA, 32'h155);
    line.send(9'h0aa, 9, 1'b1);
    rd("data9 dropped", umf_pkg::ADDR_STATUS, 32'h9);
    wr(umf_pkg::ADDR_CTRL, 32'h0e);
    clr();
    line.send(9'h03c, 9, 1'b1);
    rd("data9 taken", umf_pkg::ADDR_STATUS, 32'h1);
    rd("data9 value", umf_pkg::ADDR_RXDATA, 32'h03c);
    wr(umf_pkg::ADDR_CTRL, 32'h0f);
    clr();
    line.send(9'h0c3, 9, 1'b1);
    rd("data9 ignored", umf_pkg::ADDR_STATUS, 32'h8);
    rd("data9 kept", umf_pkg::ADDR_RXDATA, 32'h03c);
  endtask

  task automatic t_ferr();
    clr();
    wr(umf_pkg::ADDR_CTRL, 32'h0c);
    line.send(9'h05a, 8, 1'b0);
    rd("frame error", umf_pkg::ADDR_STATUS, 32'h5);
    rd("errored data", umf_pkg::ADDR_RXDATA, 32'h05a);
  endtask

  task automatic t_irq();
    clr();
    wr(umf_pkg::ADDR_MASK, 32'h1);
    line.send(9'h011, 8, 1'b1);
    irq_is(1'b1);
    wr(umf_pkg::ADDR_MASK, 32'h0);
    irq_is(1'b0);
    wr(umf_pkg::ADDR_MASK, 32'h1);
    irq_is(1'b1);
    clr();
    irq_is(1'b0);
  endtask

  // The refused write runs beside the capture, while the character is on the line.
  task automatic t_tx();
    logic [9:0] bits;
    int n;
    n = 0;
    clr();
    wr(umf_pkg::ADDR_CTRL, 32'h2f);
    wr(umf_pkg::ADDR_TXDATA, 32'ha5);
    fork
      begin
        while (txd_out !== 1'b0 && n < 100) begin
          @(negedge clk_in);
          n++;
        end
        repeat (8) @(negedge clk_in);
        for (int i = 0; i < 10; i++) begin
          repeat (16) @(negedge clk_in);
          bits[i] = txd_out;
        end
      end
      begin
        repeat (30) @(posedge clk_in);
        wr(umf_pkg::ADDR_TXDATA, 32'h11);
        chk("busy refusal", 32'h1, {31'h0, rerr});
        rd("tx busy", umf_pkg::ADDR_STATUS, 32'h100);
      end
    join
    chk("tx frame", 32'h3a5, {22'h0, bits});
    repeat (20) @(posedge clk_in);
    rd("tx complete", umf_pkg::ADDR_STATUS, 32'h2);
  endtask
  // ------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_sizes();
    t_nine();
    t_ferr();
    t_irq();
    t_tx();
    end_sim();
  end

  // About 2,800 cycles are expected; 20,000 leaves ample margin.
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule

bind umf_top umf_props u_props (.clk_in, .reset_in, .paddr_in, .psel_in, .penable_in,
  .pwrite_in, .prdata_out, .pready_out, .pslverr_out, .txd_out, .irq_out);
